/* File: include/umds_params.svh */
/*
 * offsets, field positions and reset values of the usb dma status/timeout bank.
 * assumes: included by its bare name from the core and testbench files.
 */
`ifndef UMDS_PARAMS_SVH
`define UMDS_PARAMS_SVH

// ==========================================================
// register offsets
`define UMDS_OFS_STATUS     8'h00
`define UMDS_OFS_TOUT_CNT   8'h04
`define UMDS_OFS_TOUT_CTRL  8'h08
`define UMDS_OFS_RD_REQ     8'h0c
`define UMDS_OFS_RD_VAL     8'h10

// ==========================================================
// field positions
`define UMDS_BIT_RXDSET     0
`define UMDS_BIT_TXDSET     1
`define UMDS_BIT_MW_BUF_EMPTY 2
`define UMDS_BIT_MR_BUF_EMPTY 3
`define UMDS_BIT_TXEMPTY    4
`define UMDS_BIT_TOUT_EN    0
`define UMDS_BIT_RD_PEND    31

// ==========================================================
// reset values
`define UMDS_STATUS_RST     32'h0000001c
`define UMDS_TOUT_CNT_RST   32'hffffffff
`define UMDS_TOUT_CTRL_RST  32'h00000000
`define UMDS_EP_SYNC_RST    3'h4

`endif

/* File: include/umds_pkg.sv */
/*
 * types of the usb dma status/timeout bank.
 * assumes: nothing beyond the params header.
 */
package umds_pkg;

    // ==========================================================
    // register access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } umds_req_t;

    // ==========================================================
    // register access answer
    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } umds_rsp_t;

    // ==========================================================
    // controller endpoint handshake levels (usb domain, unsynchronised)
    typedef struct packed {
        logic txEpEmpty;
        logic txEpDataSet;
        logic rxEpDataSet;
    } umds_ep_t;

    // ==========================================================
    // indirect read sequencer
    typedef enum logic [1:0] {
        RD_IDLE  = 2'b01,
        RD_FETCH = 2'b10
    } umds_rd_state_t;

endpackage

/* File: core/umds_sync.sv */
/*
 * two-flop synchroniser for a group of independent level signals.
 * assumes: each bit is a slow level; no bus coherence across bits is needed.
 */
`timescale 1ns/1ps

module umds_sync #(
    parameter int                WIDTH     = 3,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // ==========================================================
    // first stage is read only by the second stage
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1  <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

/* File: core/umds_status_timeout.sv */
/*
 * master dma status flags, debug timeout counter and indirect read path
 * of the usb bus bridge.
 * assumes: register requests are single-cycle pulses on sys_clk; buffer-empty
 * inputs are in the sys_clk domain; endpoint levels come from the usb core
 * and are synchronised here; usbClkTick marks one usb clock cycle.
 */
`timescale 1ns/1ps
`include "umds_params.svh"

// Operation
// R1: the master-read buffer empty flag in bit 3 reads 1 when the read buffer is empty.
// R2: the master-read buffer empty flag reads 0 while the read buffer holds data.
// R3: bit 2 is a read-only flag, 1 when the master-write buffer is empty and 0 when it holds data.
// R4: bit 1 goes to 1 once the transmit endpoint has been filled and has no space left.
// R5: bit 1 returns to 0 after the core has sent the endpoint data on an IN token.
// R6: the dma master moves data into the transmit endpoint only while bit 1 reads 0.
// R7: bit 1 is the core's transmit data-set level synchronised to the bus clock.
// R8: bit 0 goes to 1 when received data has been placed in the receive endpoint.
// R9: bit 0 falls to 0 only after the master-write dma has read the receive endpoint out.
// R10: bit 0 is the core's receive data-set level synchronised to the bus clock.
// R11: a 32-bit read-only debug timeout counter exists and holds all ones after reset.
// R12: the counter value is readable while the timeout enable bit is set.
// R13: the counter decrements by one per usb clock cycle once the receive endpoint has emptied.
// R14: a direct read of the counter does not return it; software requests, then reads the value register.
// R15: reading the status register has no side effect and writes to its read-only bits are ignored.
module umds_status_timeout
    import umds_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // register access
    input  wire umds_pkg::umds_req_t  regReq,
    output umds_pkg::umds_rsp_t       regRsp,
    // bridge dma buffers
    input  wire logic                 mrBufEmpty,
    input  wire logic                 mwBufEmpty,
    // usb device core handshakes
    input  wire umds_pkg::umds_ep_t   epIn,
    input  wire logic                 usbClkTick,
    // flags towards the dma master
    output logic                      txEpFull,
    output logic                      rxEpHasData
);
    import umds_pkg::*;

    // ==========================================================
    // endpoint level synchronisation
    logic [2:0] epSync;
    logic       txEpEmptyS;
    logic       txDataSetS;
    logic       rxDataSetS;

    umds_sync #(
        .WIDTH     (3),
        .RESET_VAL (`UMDS_EP_SYNC_RST)
    ) u_ep_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn ({epIn.txEpEmpty, epIn.txEpDataSet, epIn.rxEpDataSet}),
        .syncOut (epSync)
    );

    assign txEpEmptyS = epSync[2];
    assign txDataSetS = epSync[1]; // R7
    assign rxDataSetS = epSync[0]; // R10

    // ==========================================================
    // live status word
    // flags are pure views of levels, so a read cannot disturb them
    logic [31:0] statusNow;

    always_comb begin
        statusNow                     = 32'h00000000;
        statusNow[`UMDS_BIT_TXEMPTY]       = txEpEmptyS;
        statusNow[`UMDS_BIT_MR_BUF_EMPTY]  = mrBufEmpty; // R1 R2
        statusNow[`UMDS_BIT_MW_BUF_EMPTY]  = mwBufEmpty; // R3
        statusNow[`UMDS_BIT_TXDSET]        = txDataSetS; // R4
        statusNow[`UMDS_BIT_RXDSET]        = rxDataSetS; // R8
    end

    // ==========================================================
    // address decode
    // one compare per mapped offset feeds the read mux; the control and request compares also feed the write strobes
    localparam int REG_COUNT = 5;

    logic [REG_COUNT-1:0][7:0] regOffset;
    logic [REG_COUNT-1:0]      addrHit;

    assign regOffset[0] = `UMDS_OFS_STATUS;
    assign regOffset[1] = `UMDS_OFS_TOUT_CNT;
    assign regOffset[2] = `UMDS_OFS_TOUT_CTRL;
    assign regOffset[3] = `UMDS_OFS_RD_REQ;
    assign regOffset[4] = `UMDS_OFS_RD_VAL;

    for (genvar gi = 0; gi < REG_COUNT; gi++) begin : g_hit
        assign addrHit[gi] = (regReq.addr == regOffset[gi]);
    end

    // ==========================================================
    // decoded accesses
    logic wrCtrl;
    logic wrRdReq;
    logic rdAny;

    assign wrCtrl  = regReq.valid && regReq.write && addrHit[2];
    assign wrRdReq = regReq.valid && regReq.write && addrHit[3];
    assign rdAny   = regReq.valid && !regReq.write;

    // ==========================================================
    // timeout control
    logic [31:0] toutCtrl;
    logic [31:0] next_toutCtrl;
    logic        toutEnable;

    always_comb begin
        next_toutCtrl = toutCtrl;
        if (wrCtrl) begin
            next_toutCtrl                     = 32'h00000000;
            next_toutCtrl[`UMDS_BIT_TOUT_EN]  = regReq.wdata[`UMDS_BIT_TOUT_EN];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            toutCtrl <= `UMDS_TOUT_CTRL_RST;
        end else begin
            toutCtrl <= next_toutCtrl;
        end
    end

    assign toutEnable = toutCtrl[`UMDS_BIT_TOUT_EN];

    // ==========================================================
    // receive-empty arming
    // armed by the fall of the receive data-set level; new data disarms it
    // rxPrev resets to the idle level of the synced input, so reset makes no false edge
    logic cntArmed;
    logic next_cntArmed;
    logic rxPrev;
    logic next_rxPrev;
    logic rxRise;
    logic rxFall;

    assign rxRise = rxDataSetS && !rxPrev;
    assign rxFall = !rxDataSetS && rxPrev;

    always_comb begin
        next_rxPrev   = rxDataSetS;
        next_cntArmed = cntArmed;
        if (rxRise) begin
            next_cntArmed = 1'b0;
        end else if (rxFall) begin
            next_cntArmed = 1'b1; // R9
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cntArmed <= 1'b0;
            rxPrev   <= 1'b0;
        end else begin
            cntArmed <= next_cntArmed;
            rxPrev   <= next_rxPrev;
        end
    end

    // ==========================================================
    // debug timeout counter
    // new data reloads it so each empty period is timed afresh; it stops at
    // zero rather than wrap, so a long stall cannot read back as a short one
    logic [31:0] toutCnt;
    logic [31:0] next_toutCnt;

    always_comb begin
        next_toutCnt = toutCnt;
        if (rxRise) begin
            next_toutCnt = `UMDS_TOUT_CNT_RST;
        end else if (cntArmed && !rxDataSetS && usbClkTick && (toutCnt != 32'h00000000)) begin
            next_toutCnt = toutCnt - 32'h00000001; // R13
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            toutCnt <= `UMDS_TOUT_CNT_RST; // R11
        end else begin
            toutCnt <= next_toutCnt;
        end
    end

    // ==========================================================
    // indirect read path
    // a second request while one is in flight is dropped, not queued
    umds_rd_state_t rdState;
    umds_rd_state_t next_rdState;
    logic [7:0]     rdAddr;
    logic [7:0]     next_rdAddr;
    logic [31:0]    rdValue;
    logic [31:0]    next_rdValue;
    logic [31:0]    fetchData;

    always_comb begin
        unique case (rdAddr)
            `UMDS_OFS_STATUS:    fetchData = statusNow;
            `UMDS_OFS_TOUT_CNT:  fetchData = toutEnable ? toutCnt : 32'h00000000; // R12
            `UMDS_OFS_TOUT_CTRL: fetchData = toutCtrl;
            default:             fetchData = 32'h00000000;
        endcase
    end

    always_comb begin
        next_rdState = rdState;
        next_rdAddr  = rdAddr;
        next_rdValue = rdValue;
        unique case (rdState)
            RD_IDLE: begin
                if (wrRdReq) begin
                    next_rdAddr  = regReq.wdata[7:0]; // R14
                    next_rdState = RD_FETCH;
                end
            end
            RD_FETCH: begin
                next_rdValue = fetchData; // R14
                next_rdState = RD_IDLE;
            end
            default: begin
                next_rdState = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdState <= RD_IDLE;
            rdAddr  <= 8'h00;
            rdValue <= 32'h00000000;
        end else begin
            rdState <= next_rdState;
            rdAddr  <= next_rdAddr;
            rdValue <= next_rdValue;
        end
    end

    // ==========================================================
    // direct read mux
    logic [31:0] readMux;
    logic [31:0] rdReqWord;

    always_comb begin
        rdReqWord                     = 32'h00000000;
        rdReqWord[7:0]                = rdAddr;
        rdReqWord[`UMDS_BIT_RD_PEND]  = (rdState == RD_FETCH);
    end

    always_comb begin
        unique case (1'b1)
            addrHit[0]: readMux = statusNow; // R15
            addrHit[1]: readMux = 32'h00000000; // R14
            addrHit[2]: readMux = toutCtrl;
            addrHit[3]: readMux = rdReqWord;
            addrHit[4]: readMux = rdValue;
            default:    readMux = 32'h00000000;
        endcase
    end

    // ==========================================================
    // register answer
    // writes to read-only offsets land in no register and are simply absorbed
    umds_rsp_t next_regRsp;

    always_comb begin
        next_regRsp.valid = rdAny;
        next_regRsp.rdata = rdAny ? readMux : 32'h00000000;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRsp <= '0;
        end else begin
            regRsp <= next_regRsp;
        end
    end

    // ==========================================================
    // flags towards the dma master
    // one register after the synchroniser, so the master never sees a half-settled level
    logic next_txEpFull;
    logic next_rxEpHasData;

    always_comb begin
        next_txEpFull    = txDataSetS; // R5
        next_rxEpHasData = rxDataSetS; // R9
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txEpFull    <= 1'b0;
            rxEpHasData <= 1'b0;
        end else begin
            txEpFull    <= next_txEpFull; // R6
            rxEpHasData <= next_rxEpHasData;
        end
    end

endmodule

/* File: sim/umds_status_timeout_sva.sv */
/* checker for the status/timeout bank ports.
 * assumes: bound to umds_status_timeout; one clock domain. */
`timescale 1ns/1ps
module umds_status_timeout_sva
    import umds_pkg::*;
(
    // clock and reset
    input logic                sys_clk,
    input logic                sys_rst,
    // register access
    input umds_pkg::umds_req_t regReq,
    input umds_pkg::umds_rsp_t regRsp,
    // levels
    input logic                mrBufEmpty,
    input logic                mwBufEmpty,
    input umds_pkg::umds_ep_t  epIn,
    input logic                usbClkTick,
    input logic                txEpFull,
    input logic                rxEpHasData
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic rdSt;
    logic rdCnt;
    assign rdSt = regReq.valid && !regReq.write && regReq.addr == 8'h00;
    assign rdCnt = regReq.valid && !regReq.write && regReq.addr == 8'h04;
    // ==========================================
    // properties
    property p_mr; rdSt |=> regRsp.valid && regRsp.rdata[3] == $past(mrBufEmpty); endproperty
    a_mr: assert property (p_mr) else $error("mr bit");
    property p_mw; rdSt |=> regRsp.valid && regRsp.rdata[2] == $past(mwBufEmpty); endproperty
    a_mw: assert property (p_mw) else $error("mw bit");
    property p_txSet; epIn.txEpDataSet [*4] |-> txEpFull; endproperty
    a_txSet: assert property (p_txSet) else $error("tx set");
    property p_txClr; !epIn.txEpDataSet [*4] |-> !txEpFull; endproperty
    a_txClr: assert property (p_txClr) else $error("tx clear");
    property p_txSrc; txEpFull != $past(txEpFull) |-> txEpFull == $past(epIn.txEpDataSet, 3); endproperty
    a_txSrc: assert property (p_txSrc) else $error("tx source");
    property p_rxSet; epIn.rxEpDataSet [*4] |-> rxEpHasData; endproperty
    a_rxSet: assert property (p_rxSet) else $error("rx set");
    property p_rxClr; !epIn.rxEpDataSet [*4] |-> !rxEpHasData; endproperty
    a_rxClr: assert property (p_rxClr) else $error("rx clear");
    property p_rxSrc; rxEpHasData != $past(rxEpHasData) |-> rxEpHasData == $past(epIn.rxEpDataSet, 3); endproperty
    a_rxSrc: assert property (p_rxSrc) else $error("rx source");
    property p_direct; rdCnt |=> regRsp.valid && regRsp.rdata == 32'h0; endproperty
    a_direct: assert property (p_direct) else $error("direct count read");
endmodule

bind umds_status_timeout umds_status_timeout_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .regReq(regReq),
    .regRsp(regRsp), .mrBufEmpty(mrBufEmpty), .mwBufEmpty(mwBufEmpty), .epIn(epIn), .usbClkTick(usbClkTick),
    .txEpFull(txEpFull), .rxEpHasData(rxEpHasData));

/* File: sim/umds_core_model.sv */
/* usb core and dma master levels seen by the bank.
 * assumes: cmd bits (load, in token, receive, drain) are one-cycle pulses. */
`timescale 1ns/1ps
module umds_core_model
    import umds_pkg::*;
(
    // clock and reset
    input  logic               sys_clk,
    input  logic               sys_rst,
    // commands and flag
    input  logic [3:0]         cmd,
    input  logic               txEpFull,
    // levels
    output umds_pkg::umds_ep_t epIn,
    output logic               mrBufEmpty,
    output logic               mwBufEmpty,
    output logic               usbClkTick
);
    logic [1:0] mrCnt;
    logic [1:0] mwCnt;
    logic       txSet;
    logic       rxSet;
    assign mrBufEmpty = mrCnt == 2'h0;
    assign mwBufEmpty = mwCnt == 2'h0;
    assign epIn = {!txSet, txSet, rxSet};
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mrCnt <= 2'h0;
            mwCnt <= 2'h0;
            txSet <= 1'h0;
            rxSet <= 1'h0;
            usbClkTick <= 1'h0;
        end else begin
            usbClkTick <= !usbClkTick;
            // a load request is dropped while the flag says full
            if (cmd[3] && !txEpFull && mrCnt == 2'h0) mrCnt <= 2'h3;
            else if (mrCnt != 2'h0) mrCnt <= mrCnt - 2'h1;
            if (mrCnt == 2'h1) txSet <= 1'h1;
            if (cmd[2]) txSet <= 1'h0;
            if (cmd[1]) rxSet <= 1'h1;
            if (cmd[0] && rxSet && mwCnt == 2'h0) mwCnt <= 2'h3;
            else if (mwCnt != 2'h0) mwCnt <= mwCnt - 2'h1;
            if (mwCnt == 2'h1) rxSet <= 1'h0;
        end
    end
endmodule

/* File: sim/umds_tb.sv */
/* self-checking bench for the status/timeout bank.
 * assumes: the core model supplies every endpoint and buffer level. */
`timescale 1ns/1ps
`include "umds_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
    import umds_pkg::*;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    umds_req_t regReq = '0;
    umds_rsp_t regRsp;
    umds_ep_t epIn;
    logic mrBufEmpty, mwBufEmpty, usbClkTick, txEpFull, rxEpHasData;
    logic [3:0] cmd = 4'h0;
    logic [15:0] seed = 16'h001f;
    logic [31:0] v1, v2, d;
    int errors = 0, check_count = 0, cyc = 0;
    always #50 sys_clk = !sys_clk;
    umds_status_timeout u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regReq(regReq), .regRsp(regRsp),
        .mrBufEmpty(mrBufEmpty), .mwBufEmpty(mwBufEmpty), .epIn(epIn), .usbClkTick(usbClkTick),
        .txEpFull(txEpFull), .rxEpHasData(rxEpHasData));
    umds_core_model u_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd), .txEpFull(txEpFull),
        .epIn(epIn), .mrBufEmpty(mrBufEmpty), .mwBufEmpty(mwBufEmpty), .usbClkTick(usbClkTick));
    // ==========================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] stat(input umds_ep_t e, input logic mr, input logic mw);
        return {27'h0, e.txEpEmpty, mr, mw, e.txEpDataSet, e.rxEpDataSet};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge sys_clk) regReq <= '{1'h1, 1'h1, a, w};
        @(posedge sys_clk) regReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge sys_clk) regReq <= '{1'h1, 1'h0, a, 32'h0};
        @(posedge sys_clk) regReq <= '0;
        #1;
        `CHK("answer strobe", 1'h1, regRsp.valid)
        r = regRsp.rdata;
    endtask
    // request then fetch: the value register is ready two edges after the request
    task automatic idx(output logic [31:0] r);
        wr(`UMDS_OFS_RD_REQ, {24'h0, `UMDS_OFS_TOUT_CNT});
        rd(`UMDS_OFS_RD_VAL, r);
    endtask
    task automatic pulse(input logic [3:0] c);
        @(posedge sys_clk) cmd <= c;
        @(posedge sys_clk) cmd <= 4'h0;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up();
        end
    end
    // ==========================================
    // sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'h0;
        rd(`UMDS_OFS_STATUS, d);
        `CHK("status after reset", `UMDS_STATUS_RST, d)
        wr(`UMDS_OFS_STATUS, 32'hffffffff);
        rd(`UMDS_OFS_STATUS, d);
        `CHK("status after write", stat(epIn, mrBufEmpty, mwBufEmpty), d)
        rd(`UMDS_OFS_TOUT_CNT, d);
        `CHK("direct count read", 32'h0, d)
        idx(d);
        `CHK("count with enable low", 32'h0, d)
        wr(`UMDS_OFS_TOUT_CTRL, 32'h1);
        idx(d);
        `CHK("count after reset", `UMDS_TOUT_CNT_RST, d)
        pulse(4'h2);
        repeat (4) @(posedge sys_clk);
        pulse(4'h9);
        rd(`UMDS_OFS_STATUS, d);
        `CHK("buffer bits while busy", 2'h0, d[3:2])
        repeat (8) @(posedge sys_clk);
        idx(v1);
        repeat (20) @(posedge sys_clk);
        idx(v2);
        `CHK("count decrement", 32'hc, v1 - v2)
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            pulse(seed[3:0]);
            repeat (6) @(posedge sys_clk);
            rd(`UMDS_OFS_STATUS, d);
            `CHK("status flags", stat(epIn, mrBufEmpty, mwBufEmpty), d)
            `CHK("tx full flag", epIn.txEpDataSet, txEpFull)
            `CHK("rx data flag", epIn.rxEpDataSet, rxEpHasData)
        end
        wrap_up();
    end
endmodule
